// *** core/ddrcd_ctrl.sv ***
// controller end: drives command pins from a user request
`timescale 1ns/10ps
module ddrcd_ctrl (
    // clock, reset, enable
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    // command request
    input wire logic [3:0] I_CMD,
    input wire logic I_CMD_VALID,
    output logic O_CMD_READY,
    input wire logic [1:0] I_BANK,
    input wire logic [12:0] I_ADDR,
    // write data source
    input wire logic [7:0] I_WDATA,
    input wire logic I_DM,
    input wire logic I_WVALID,
    output logic O_WREADY,
    // link
    ddrcd_if.ctrl link
);
    logic [7:0] lock_r;
    logic [2:0] pins;
    logic dll_on, is_rd, take, sr_exit;
    ddrcd_pkg::ddrcd_cmd_e c;
    assign c = ddrcd_pkg::ddrcd_cmd_e'(I_CMD);
    assign is_rd = c == ddrcd_pkg::DDRCD_RD;
    // hold reads until the dll has settled
    assign O_CMD_READY = !(is_rd && lock_r != 8'h00);
    assign take = I_CMD_VALID && O_CMD_READY && I_CE;
    // extended load with dll disable bit low
    assign dll_on = take && c == ddrcd_pkg::DDRCD_LMR && I_BANK == ddrcd_pkg::BANK_EXT
                    && !I_ADDR[ddrcd_pkg::EXT_DLL_DIS_BIT];
    // any take other than self refresh while cke is low leaves self refresh, which turns the dll on
    assign sr_exit = take && !link.cke && c != ddrcd_pkg::DDRCD_SREF;
    always_comb begin
        case (c)
            ddrcd_pkg::DDRCD_ACT: pins = 3'h3;
            ddrcd_pkg::DDRCD_RD: pins = 3'h5;
            ddrcd_pkg::DDRCD_WR: pins = 3'h4;
            ddrcd_pkg::DDRCD_BST: pins = 3'h6;
            ddrcd_pkg::DDRCD_PRE: pins = 3'h2;
            ddrcd_pkg::DDRCD_AREF: pins = 3'h1;
            ddrcd_pkg::DDRCD_SREF: pins = 3'h1;
            ddrcd_pkg::DDRCD_LMR: pins = 3'h0;
            default: pins = 3'h7;
        endcase
    end
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            link.cs_n <= 1'b1;
            {link.ras_n, link.cas_n, link.we_n} <= 3'h7;
            link.cke <= 1'b1;
            link.ba <= 2'h0;
            link.addr <= 13'h0000;
            lock_r <= 8'h00;
        end else if (I_CE) begin
            link.cs_n <= !(take && c != ddrcd_pkg::DDRCD_NOP);
            {link.ras_n, link.cas_n, link.we_n} <= take ? pins : 3'h7;
            // cke drops only for self refresh
            if (take && c == ddrcd_pkg::DDRCD_SREF) link.cke <= 1'b0;
            else if (take) link.cke <= 1'b1;
            link.ba <= I_BANK;
            link.addr <= I_ADDR;
            if (dll_on || sr_exit) lock_r <= ddrcd_pkg::DLL_LOCK_CNT;
            else if (lock_r != 8'h00 && link.cke) lock_r <= lock_r - 8'h01;
        end
    end
    assign link.wdata = I_WDATA;
    assign link.dm = I_DM;
    assign link.wvalid = I_WVALID;
    assign O_WREADY = link.wready;
endmodule

// *** core/ddrcd_dev.sv ***
// device end: command decode, mode registers, masked write path
// Behaviour
// - ba 01 loads extended, 00 base register
// - extended register holds dll and drive
// - controller resets dll after enabling it
// - controller loads registers only when idle; code takes a load request in any bank state
// - dll must be enabled for operation
// - self refresh exit re-enables dll
// - no read within 200 cycles of dll enable
// - fet control output not implemented
// - deselect and nop act identically
// - activate takes bank and row
// - read or write takes bank and column
// - a10 requests per-command auto precharge
// - burst terminate decoded, reads only; code issues and decodes it after any command
// - precharge one bank or all banks
// - refresh: auto with cke, self without
// - refresh row from internal counter
// - mode load stores a0-a12 opcode
// - data mask high blocks write element
// - controller keeps cke high except self refresh
// - base load with a8 resets dll, self-clearing; code also requires a7 and a9-a12 low
`timescale 1ns/10ps
module ddrcd_dev #(
    parameter int WIDTH = 8,
    parameter int ROW_W = 13
) (
    // clock, reset, enable
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    // link
    ddrcd_if.dev link,
    // decoded command
    output logic [3:0] O_CMD,
    output logic O_CMD_VALID,
    output logic [1:0] O_BANK,
    output logic [12:0] O_ADDR,
    output logic O_AUTO_PRE,
    output logic O_PRE_ALL,
    output logic [ROW_W-1:0] O_REF_ROW,
    // mode state
    output logic [12:0] O_BASE_MODE,
    output logic [12:0] O_EXT_MODE,
    output logic O_DLL_EN,
    output logic O_DLL_RST,
    output logic O_SELF_REF,
    output logic O_READ_EARLY,
    // write data sink
    output logic [WIDTH-1:0] O_WDATA,
    output logic O_WVALID,
    input wire logic I_WREADY
);
    // the link carries eight data bits, so a wider sink has nothing to fill it
    if (WIDTH < 1 || WIDTH > 8 || ROW_W < 1) begin : g_bad_param
        $error("bad parameter");
    end
    logic sel, row_l, col_l, we_l;
    ddrcd_pkg::ddrcd_cmd_e cmd;
    assign sel = !link.cs_n;
    assign row_l = !link.ras_n;
    assign col_l = !link.cas_n;
    assign we_l = !link.we_n;
    // deselect falls into nop regardless of other lines
    always_comb begin
        cmd = ddrcd_pkg::DDRCD_NOP;
        if (sel) begin
            case ({row_l, col_l, we_l})
                3'h4: cmd = ddrcd_pkg::DDRCD_ACT;
                3'h2: cmd = ddrcd_pkg::DDRCD_RD;
                3'h3: cmd = ddrcd_pkg::DDRCD_WR;
                3'h1: cmd = ddrcd_pkg::DDRCD_BST;
                3'h5: cmd = ddrcd_pkg::DDRCD_PRE;
                3'h6: cmd = link.cke ? ddrcd_pkg::DDRCD_AREF
                                     : ddrcd_pkg::DDRCD_SREF;
                3'h7: cmd = ddrcd_pkg::DDRCD_LMR;
                default: cmd = ddrcd_pkg::DDRCD_NOP;
            endcase
        end
    end
    logic is_rw, is_ref, is_lmr, ld_base, ld_ext, sref_exit;
    assign is_rw = (cmd == ddrcd_pkg::DDRCD_RD) || (cmd == ddrcd_pkg::DDRCD_WR);
    assign is_ref = (cmd == ddrcd_pkg::DDRCD_AREF) || (cmd == ddrcd_pkg::DDRCD_SREF);
    assign is_lmr = cmd == ddrcd_pkg::DDRCD_LMR;
    // reserved bank codes are ignored
    assign ld_base = is_lmr && link.ba == ddrcd_pkg::BANK_BASE;
    assign ld_ext = is_lmr && link.ba == ddrcd_pkg::BANK_EXT;
    assign sref_exit = O_SELF_REF && link.cke;
    logic [12:0] base_r, ext_r, ext_nxt;
    logic dll_rst_r, sref_r, dll_force_r;
    logic [7:0] lock_r;
    logic [ROW_W-1:0] ref_row_r;
    logic dll_en;
    // self refresh exit overrides a disable bit
    assign dll_en = !ext_r[ddrcd_pkg::EXT_DLL_DIS_BIT] || dll_force_r;
    // opcode stored whole; no fet control output exists
    assign ext_nxt = link.addr;
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            base_r <= ddrcd_pkg::BASE_RESET;
            ext_r <= ddrcd_pkg::EXT_RESET;
            dll_rst_r <= 1'b0;
            sref_r <= 1'b0;
            dll_force_r <= 1'b0;
        end else if (I_CE) begin
            if (ld_base) begin
                base_r <= link.addr;
                base_r[ddrcd_pkg::DLL_RST_BIT] <= 1'b0;
            end
            if (ld_ext) begin
                ext_r <= ext_nxt;
                dll_force_r <= 1'b0;
            end
            dll_rst_r <= ld_base && link.addr[ddrcd_pkg::DLL_RST_BIT]
                         && link.addr[7] == 1'b0 && link.addr[12:9] == 4'h0;
            if (cmd == ddrcd_pkg::DDRCD_SREF) sref_r <= 1'b1;
            else if (sref_exit) begin
                sref_r <= 1'b0;
                dll_force_r <= 1'b1;
            end
        end
    end
    // lockout starts on the edge that turns the dll on; that edge is the first cycle
    logic dll_on_now;
    assign dll_on_now = !dll_en
                        && ((ld_ext && !link.addr[ddrcd_pkg::EXT_DLL_DIS_BIT]) || sref_exit);
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            lock_r <= 8'h00;
        end else if (I_CE) begin
            if (dll_on_now) lock_r <= ddrcd_pkg::DLL_LOCK_CNT - 8'h01;
            else if (lock_r != 8'h00 && link.cke) lock_r <= lock_r - 8'h01;
        end
    end
    // refresh row comes from the counter, address ignored
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) ref_row_r <= '0;
        else if (I_CE && is_ref) ref_row_r <= ref_row_r + 1'b1;
    end
    // registered command outputs
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            O_CMD <= 4'h0;
            O_CMD_VALID <= 1'b0;
            O_BANK <= 2'h0;
            O_ADDR <= 13'h0000;
            O_AUTO_PRE <= 1'b0;
            O_PRE_ALL <= 1'b0;
            O_READ_EARLY <= 1'b0;
        end else if (I_CE) begin
            O_CMD <= cmd;
            O_CMD_VALID <= cmd != ddrcd_pkg::DDRCD_NOP;
            O_BANK <= is_ref ? 2'h0 : link.ba;
            // column keeps a0-a9 and a11 only
            O_ADDR <= is_rw ? (link.addr & 13'h0bff) : (is_ref ? 13'h0000 : link.addr);
            O_AUTO_PRE <= is_rw && link.addr[ddrcd_pkg::AP_BIT];
            O_PRE_ALL <= cmd == ddrcd_pkg::DDRCD_PRE
                         && link.addr[ddrcd_pkg::AP_BIT];
            O_READ_EARLY <= lock_r != 8'h00 && cmd == ddrcd_pkg::DDRCD_RD;
        end
    end
    assign O_REF_ROW = ref_row_r;
    assign O_BASE_MODE = base_r;
    assign O_EXT_MODE = ext_r;
    assign O_DLL_EN = dll_en;
    assign O_DLL_RST = dll_rst_r;
    assign O_SELF_REF = sref_r;
    // two-entry buffer; masked elements dropped on entry
    logic [WIDTH-1:0] buf_r [2];
    logic [1:0] cnt_r;
    logic wr_ptr_r, rd_ptr_r, push, pop;
    assign link.wready = cnt_r != 2'h2;
    assign push = link.wvalid && link.wready && !link.dm && I_CE;
    assign pop = O_WVALID && I_WREADY && I_CE;
    assign O_WVALID = cnt_r != 2'h0;
    assign O_WDATA = buf_r[rd_ptr_r];
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            cnt_r <= 2'h0;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            buf_r[0] <= '0;
            buf_r[1] <= '0;
        end else begin
            if (push) begin
                buf_r[wr_ptr_r] <= link.wdata[WIDTH-1:0];
                wr_ptr_r <= !wr_ptr_r;
            end
            if (pop) rd_ptr_r <= !rd_ptr_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// *** core/ddrcd_if.sv ***
// command and write-data pins between controller and memory device
`timescale 1ns/10ps
interface ddrcd_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [7:0] wdata;
    logic dm;
    logic wvalid;
    logic wready;
    modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, ba, addr, wdata, dm, wvalid,
                  input wready);
    modport dev (input cs_n, ras_n, cas_n, we_n, cke, ba, addr, wdata, dm, wvalid,
                 output wready);
endinterface

// *** core/ddrcd_pkg.sv ***
// shared constants for the ddr command decode link
package ddrcd_pkg;
    localparam int ADDR_W = 13;
    localparam int BANK_W = 2;
    localparam int COL_LO_W = 10;
    localparam int AP_BIT = 10;
    localparam int COL_HI_BIT = 11;
    localparam int DLL_RST_BIT = 8;
    // extended register fields
    localparam int EXT_DLL_DIS_BIT = 0;
    localparam int EXT_DRV_BIT = 1;
    localparam logic [ADDR_W-1:0] EXT_RESET = 13'h0000;
    localparam logic [ADDR_W-1:0] BASE_RESET = 13'h0000;
    localparam logic [BANK_W-1:0] BANK_BASE = 2'h0;
    localparam logic [BANK_W-1:0] BANK_EXT = 2'h1;
    // read lockout after dll enable, in clock cycles
    localparam int DLL_LOCK_CYC = 200;
    localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CYC);
    typedef enum logic [3:0] {
        DDRCD_NOP = 4'h0,
        DDRCD_ACT = 4'h1,
        DDRCD_RD = 4'h2,
        DDRCD_WR = 4'h3,
        DDRCD_BST = 4'h4,
        DDRCD_PRE = 4'h5,
        DDRCD_AREF = 4'h6,
        DDRCD_SREF = 4'h7,
        DDRCD_LMR = 4'h8
    } ddrcd_cmd_e;
endpackage

// *** tb/ddrcd_checker.sv ***
// assertions on the command and write-data pins of the link
`timescale 1ns/10ps
module ddrcd_checker (
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST_N,
    // link pins
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic cke,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    input wire logic [7:0] wdata,
    input wire logic dm,
    input wire logic wvalid,
    input wire logic wready
);
    default clocking @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RST_N);
    wire rd_pin = !cs_n && ras_n && !cas_n && we_n;
    wire ref_pin = !cs_n && !ras_n && !cas_n && we_n;
    wire idle_pin = cs_n || (ras_n && cas_n && we_n);
    // extended load that enables the dll starts the read lockout
    wire dll_on = !cs_n && !ras_n && !cas_n && !we_n && ba == 2'h1 && !addr[0];
    // self refresh exit also turns the dll on
    logic sr_r;
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N)
            sr_r <= 1'b0;
        else if (ref_pin && !cke)
            sr_r <= 1'b1;
        else if (cke)
            sr_r <= 1'b0;
    end
    // the enabling edge is itself the first lockout cycle
    logic [7:0] lock_r;
    always_ff @(posedge I_MCLK) begin
        if (!I_RST_N)
            lock_r <= 8'h00;
        else if (dll_on || (sr_r && cke))
            lock_r <= ddrcd_pkg::DLL_LOCK_CNT - 8'h01;
        else if (cke && lock_r != 8'h00)
            lock_r <= lock_r - 8'h01;
    end
    reset_idle_a: assert property ($rose(I_RST_N) |-> cs_n && cke)
        else $error("pins not idle after reset");
    cke_fall_a: assert property ($fell(cke) |-> ref_pin)
        else $error("clock enable fell without self refresh");
    cke_cmd_a: assert property (!idle_pin && !ref_pin |-> cke)
        else $error("command issued with clock enable low");
    sref_hold_a: assert property (ref_pin && !cke |=> !cke)
        else $error("self refresh left at once");
    read_lock_a: assert property (rd_pin |-> lock_r == 8'h00)
        else $error("read inside dll lockout");
    lock_start_a: assert property (dll_on |=> !rd_pin [*8])
        else $error("read right after dll enable");
    wvalid_hold_a: assert property (wvalid && !wready |=> wvalid)
        else $error("write valid dropped while stalled");
    wdata_hold_a: assert property (wvalid && !wready |=> $stable(wdata) && $stable(dm))
        else $error("write word changed while stalled");
    cover property (ref_pin && !cke);
    cover property (wvalid && !wready);
    cover property (dll_on);
endmodule

// *** tb/tb_top.sv ***
// self-checking bench joining controller and device ends
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cmd_v = 1'b0, dm = 1'b0, wv = 1'b0, wrdy = 1'b0;
    logic [3:0] cmd = 4'h0, ocmd;
    logic [1:0] bank = 2'h0, ob;
    logic [12:0] addr = 13'h0000, oa, orow, obase, oext, r0;
    logic [7:0] wd = 8'h00, owd;
    logic cmd_rdy, o_wrdy, cv, ap, pa, dll_en, dll_rst, sref, ov, rde;
    logic [7:0] got[$];
    int error_cnt = 0, checks = 0, cyc = 0, tk = 0, tk0 = 0;
    ddrcd_if link_if ();
    ddrcd_ctrl ddrcd_ctrl_inst (.I_MCLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_CMD(cmd),
        .I_CMD_VALID(cmd_v), .O_CMD_READY(cmd_rdy), .I_BANK(bank), .I_ADDR(addr),
        .I_WDATA(wd), .I_DM(dm), .I_WVALID(wv), .O_WREADY(o_wrdy), .link(link_if));
    ddrcd_dev #(.WIDTH(8), .ROW_W(13)) ddrcd_dev_inst (.I_MCLK(clk), .I_RST_N(rst_n),
        .I_CE(ce), .link(link_if), .O_CMD(ocmd), .O_CMD_VALID(cv), .O_BANK(ob), .O_ADDR(oa),
        .O_AUTO_PRE(ap), .O_PRE_ALL(pa), .O_REF_ROW(orow), .O_BASE_MODE(obase),
        .O_EXT_MODE(oext), .O_DLL_EN(dll_en), .O_DLL_RST(dll_rst), .O_SELF_REF(sref),
        .O_READ_EARLY(rde), .O_WDATA(owd), .O_WVALID(ov), .I_WREADY(wrdy));
    ddrcd_checker ddrcd_checker_inst (.I_MCLK(clk), .I_RST_N(rst_n), .cs_n(link_if.cs_n),
        .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n), .cke(link_if.cke),
        .ba(link_if.ba), .addr(link_if.addr), .wdata(link_if.wdata), .dm(link_if.dm),
        .wvalid(link_if.wvalid), .wready(link_if.wready));
    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) if (ov === 1'b1 && wrdy === 1'b1) got.push_back(owd);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // outputs land one edge after the take edge and stand one cycle
    task automatic req(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        int n;
        n = 0;
        @(negedge clk);
        cmd = c;
        bank = b;
        addr = a;
        cmd_v = 1'b1;
        do @(posedge clk); while (cmd_rdy !== 1'b1 && n++ < 400);
        chk("ready", cmd_rdy, 1'b1);
        tk = cyc;
        @(negedge clk);
        cmd_v = 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic dcmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        req(c, b, a);
        chk("command", {cv, ocmd}, {1'b1, c});
    endtask
    task automatic push(input logic [7:0] d, input logic m);
        int n;
        n = 0;
        @(negedge clk);
        wd = d;
        dm = m;
        wv = 1'b1;
        do @(posedge clk); while (o_wrdy !== 1'b1 && n++ < 50);
        chk("wready", o_wrdy, 1'b1);
        @(negedge clk);
        wv = 1'b0;
    endtask
    initial begin
        #(2000 * 100);
        error_cnt++;
        results;
    end
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        dcmd(ddrcd_pkg::DDRCD_ACT, 2'h2, 13'h1abc);
        chk("act", {ob, oa}, {2'h2, 13'h1abc});
        dcmd(ddrcd_pkg::DDRCD_WR, 2'h3, 13'h0555);
        chk("write", {ob, oa, ap}, {2'h3, 13'h0155, 1'b1});
        dcmd(ddrcd_pkg::DDRCD_RD, 2'h1, 13'h1bff);
        chk("read", {ob, oa, ap, rde}, {2'h1, 13'h0bff, 1'b0, 1'b0});
        // terminate only a read burst without auto precharge
        dcmd(ddrcd_pkg::DDRCD_BST, 2'h0, 13'h0000);
        dcmd(ddrcd_pkg::DDRCD_PRE, 2'h2, 13'h0400);
        chk("pre all", pa, 1'b1);
        dcmd(ddrcd_pkg::DDRCD_PRE, 2'h3, 13'h0000);
        chk("pre one", {ob, pa}, {2'h3, 1'b0});
        dcmd(ddrcd_pkg::DDRCD_AREF, 2'h0, 13'h0000);
        r0 = orow;
        dcmd(ddrcd_pkg::DDRCD_AREF, 2'h3, 13'h1234);
        chk("refresh row", orow, r0 + 13'h0001);
        dcmd(ddrcd_pkg::DDRCD_LMR, 2'h1, 13'h0002);
        tk0 = tk;
        chk("ext mode", {oext, dll_en}, {13'h0002, 1'b1});
        dcmd(ddrcd_pkg::DDRCD_LMR, 2'h0, 13'h0100);
        chk("enable reset", {dll_rst, obase}, {1'b1, 13'h0000});
        dcmd(ddrcd_pkg::DDRCD_RD, 2'h0, 13'h0000);
        chk("lockout", 32'(tk - tk0 >= 200), 32'h1);
        chk("read early", rde, 1'b0);
        dcmd(ddrcd_pkg::DDRCD_LMR, 2'h1, 13'h0003);
        chk("dll off", dll_en, 1'b0);
        dcmd(ddrcd_pkg::DDRCD_LMR, 2'h0, 13'h0132);
        chk("dll reset", {dll_rst, obase, oext}, {1'b1, 13'h0032, 13'h0003});
        req(ddrcd_pkg::DDRCD_LMR, 2'h2, 13'h1555);
        chk("reserved", {obase, oext}, {13'h0032, 13'h0003});
        dcmd(ddrcd_pkg::DDRCD_SREF, 2'h0, 13'h0000);
        chk("self ref", sref, 1'b1);
        req(ddrcd_pkg::DDRCD_NOP, 2'h0, 13'h0000);
        chk("sr exit", {sref, dll_en}, {1'b0, 1'b1});
        chk("nop", cv, 1'b0);
        // stalled sink: masked word must not take a slot
        push(8'ha5, 1'b0);
        push(8'h3c, 1'b1);
        push(8'h5a, 1'b0);
        @(negedge clk);
        chk("full", o_wrdy, 1'b0);
        wrdy = 1'b1;
        push(8'hc3, 1'b0);
        repeat (6) @(posedge clk);
        chk("words", {8'(got.size()), got[0], got[1], got[2]}, {8'h03, 24'ha55ac3});
        // enable low: a pending request waits and nothing moves
        @(negedge clk);
        ce = 1'b0;
        cmd = ddrcd_pkg::DDRCD_ACT;
        cmd_v = 1'b1;
        repeat (3) @(negedge clk);
        chk("frozen", {link_if.cs_n, cv}, 2'h2);
        ce = 1'b1;
        @(negedge clk);
        cmd_v = 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk("resumed", {cv, ocmd}, {1'b1, ddrcd_pkg::DDRCD_ACT});
        results;
    end
endmodule
